/* File: hdl/sfcfe_front_end.v */
// Serial interface front end of a small serial NOR flash.
// Assumes pins arrive asynchronously; the array is not modelled.
// Operation
// R1 - Array is four 64K blocks of sixteen 4K sectors, top 0x03ffff.
// R2 - Unknown command: standby, output off, ignore until select falls.
// R3 - Valid command stays active until select rises.
// R4 - Sample on rising clock edge, shift out on falling; mode 0 and 3.
// R5 - Read commands output data; host may stop after any bit.
// R6 - Write-type commands execute only on whole-byte select rise.
// R7 - Array access is ignored while an internal cycle runs.
// R8 - Power-up puts the command machine in standby.
// R9 - Program, erase, status write refused while latch is clear.
// R10 - Latch cleared at power-up and after disable or write commands.
// R11 - Deep power-down accepts only release and signature commands.
// R12 - Protect bits block program and erase by block level.
// R13 - Protect pin low guards protect bits and lock bit.
// R14 - Pause starts on pause pin fall once clock is low.
// R15 - Pause ends on pause pin rise once clock is low.
// R16 - While paused output is off, input and clock ignored.
// R17 - Pausing does not disturb an internal cycle.
// R18 - Select rising during pause resets interface logic.
// R19 - Decode the listed opcodes.
// R20 - Lock bit with pin low refuses status write.
// R21 - Status bit 0 shows write in progress.
// R22 - Bytes most significant bit first; bit count restarts on select.
`timescale 1ns/10ps
`include "sfcfe_consts.vh"
module sfcfe_front_end
#(
  parameter BUSY_CYCLES = `SFCFE_BUSY_CYCLES,
  parameter [7:0] SIG_ID = 8'h11, // arbitrary value
  parameter [7:0] MAKER_ID = 8'h22, // arbitrary value
  parameter [7:0] TYPE_ID = 8'h33, // arbitrary value
  parameter [7:0] DENS_ID = 8'h12  // arbitrary value
)
(
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        si,
  input  wire        wp_n,
  input  wire        pause_n,
  input  wire [7:0]  array_rdata,
  output reg         so_o,
  output reg         so_oe,
  output reg  [17:0] array_addr_r,
  output reg         array_rd_r,
  output reg         prog_start_r,
  output reg         erase_start_r,
  output reg  [1:0]  erase_kind_r,
  output reg  [7:0]  status_r,
  output reg         power_down_r,
  output reg         bad_cmd_r
);
  localparam ST_IDLE = 3'd0;
  localparam ST_CMD  = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_DUMMY= 3'd3;
  localparam ST_DATA = 3'd4;
  localparam ST_IGN  = 3'd5;
  localparam ST_WAIT = 3'd6;
  // ------------------------------------------------------------------
  // Opcode classification
  // ------------------------------------------------------------------
  // R19 opcode decode
  function is_known;
    input [7:0] op;
    begin
      case (op)
        `SFCFE_OP_SET_WRITE_LATCH_CMD_CODE, `SFCFE_OP_CLEAR_WRITE_LATCH_CMD_CODE, `SFCFE_OP_STATUS_WRITE_CMD_CODE,
        `SFCFE_OP_IDENTIFICATION_READ_CMD_CODE, `SFCFE_OP_STATUS_READ_CMD_CODE, `SFCFE_OP_READ_CODE,
        `SFCFE_OP_FAST_CODE, `SFCFE_OP_SFDP_CODE, `SFCFE_OP_DUAL_CODE,
        `SFCFE_OP_SIG_CODE, `SFCFE_OP_MAKER_CODE, `SFCFE_OP_SECT_CODE,
        `SFCFE_OP_BLK1_CODE, `SFCFE_OP_BLK2_CODE, `SFCFE_OP_CHIP1_CODE,
        `SFCFE_OP_CHIP2_CODE, `SFCFE_OP_PROG_CODE, `SFCFE_OP_PDN_CODE:
          is_known = 1'b1;
        default:
          is_known = 1'b0;
      endcase
    end
  endfunction
  function needs_addr;
    input [7:0] op;
    begin
      case (op)
        `SFCFE_OP_READ_CODE, `SFCFE_OP_FAST_CODE, `SFCFE_OP_SFDP_CODE,
        `SFCFE_OP_DUAL_CODE, `SFCFE_OP_SECT_CODE, `SFCFE_OP_BLK1_CODE,
        `SFCFE_OP_BLK2_CODE, `SFCFE_OP_PROG_CODE, `SFCFE_OP_MAKER_CODE:
          needs_addr = 1'b1;
        default:
          needs_addr = 1'b0;
      endcase
    end
  endfunction
  // R12 protected block test
  function blocked;
    input [1:0]  lvl;
    input [17:0] a;
    begin
      case (lvl)
        2'd0:    blocked = 1'b0;
        2'd1:    blocked = (a[17:16] == 2'd3);
        2'd2:    blocked = a[17];
        default: blocked = 1'b1;
      endcase
    end
  endfunction
  // ------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ------------------------------------------------------------------
  wire [4:0] pins_s;
  sfcfe_sync #(.W(5)) u_sync
  (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in ({pause_n, wp_n, si, cs_n, sclk}),
    .sync_out (pins_s)
  );
  wire sclk_s  = pins_s[0];
  wire cs_s    = pins_s[1];
  wire si_s    = pins_s[2];
  wire wp_s    = pins_s[3];
  wire pause_s = pins_s[4];
  reg  sclk_d_r;
  reg  cs_d_r;
  reg  paused_r;
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire cs_fall   = ~cs_s & cs_d_r;
  wire cs_rise   = cs_s & ~cs_d_r;
  // ------------------------------------------------------------------
  // Command engine
  // ------------------------------------------------------------------
  reg [2:0]  state_r;
  reg [7:0]  shift_r;
  reg [7:0]  op_r;
  reg [2:0]  bit_r;
  reg [1:0]  byte_r;
  reg [7:0]  out_r;
  reg [15:0] busy_cnt_r;
  reg [1:0]  out_idx_r;
  wire [7:0] shift_nxt = {shift_r[6:0], si_s};
  wire       write_enable_latch   = status_r[`SFCFE_ST_WEL_POS];
  wire       busy  = status_r[`SFCFE_ST_WIP_POS];
  wire [1:0] level = status_r[`SFCFE_ST_BP1_POS:`SFCFE_ST_BP0_POS];
  // R20 hardware protection mode
  wire       hw_lock = status_r[`SFCFE_ST_LOCK_POS] & ~wp_s;
  wire       active  = ~cs_s & ~paused_r;
  wire [1:0] idx_nxt = out_idx_r + 2'd1;
  // Only array reads fetch their bytes through the array port.
  wire       arr_op  = (op_r == `SFCFE_OP_READ_CODE) ||
                       (op_r == `SFCFE_OP_FAST_CODE) ||
                       (op_r == `SFCFE_OP_SFDP_CODE) ||
                       (op_r == `SFCFE_OP_DUAL_CODE);
  reg  [7:0] id_byte;
  always @*
  begin
    case (idx_nxt)
      2'd0:    id_byte = MAKER_ID;
      2'd1:    id_byte = TYPE_ID;
      default: id_byte = DENS_ID;
    endcase
  end
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // R8 standby at power-up
      state_r <= ST_IDLE;
      // R10 latch cleared at power-up
      status_r      <= `SFCFE_ST_RESET;
      sclk_d_r      <= 1'b0;
      cs_d_r        <= 1'b1;
      paused_r      <= 1'b0;
      shift_r       <= 8'h00;
      op_r          <= 8'h00;
      bit_r         <= 3'd0;
      byte_r        <= 2'd0;
      out_r         <= 8'h00;
      out_idx_r     <= 2'd0;
      busy_cnt_r    <= 16'h0000;
      so_o          <= 1'b0;
      so_oe         <= 1'b0;
      array_addr_r  <= 18'h00000;
      array_rd_r    <= 1'b0;
      prog_start_r  <= 1'b0;
      erase_start_r <= 1'b0;
      erase_kind_r  <= 2'd0;
      power_down_r  <= 1'b0;
      bad_cmd_r     <= 1'b0;
    end
    else
    begin
      sclk_d_r      <= sclk_s;
      cs_d_r        <= cs_s;
      array_rd_r    <= 1'b0;
      prog_start_r  <= 1'b0;
      erase_start_r <= 1'b0;
      bad_cmd_r     <= 1'b0;
      // R17 internal cycle runs regardless of pause
      if (busy)
      begin
        if (busy_cnt_r == 16'h0001)
          status_r[`SFCFE_ST_WIP_POS] <= 1'b0;
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
      // R14 pause begins once clock is low
      if (~cs_s & ~pause_s & ~sclk_s & ~paused_r)
        paused_r <= 1'b1;
      // R15 pause ends once clock is low
      else if (paused_r & pause_s & ~sclk_s)
        paused_r <= 1'b0;
      // R16 output off while paused or deselected
      if (paused_r | cs_s | state_r != ST_DATA)
        so_oe <= 1'b0;
      if (cs_fall)
      begin
        // R22 bit count restarts
        bit_r   <= 3'd0;
        byte_r  <= 2'd0;
        state_r <= ST_CMD;
      end
      else if (cs_rise)
      begin
        // R18 select rise resets interface, also during pause
        paused_r <= 1'b0;
        state_r  <= ST_IDLE;
        so_oe    <= 1'b0;
        // R6 execute only on a byte boundary
        if ((state_r == ST_WAIT ||
             (state_r == ST_DATA && op_r == `SFCFE_OP_SIG_CODE)) &&
            bit_r == 3'd0)
        begin
          case (op_r)
            `SFCFE_OP_SET_WRITE_LATCH_CMD_CODE:
              if (!busy)
                status_r[`SFCFE_ST_WEL_POS] <= 1'b1;
            // R10 latch cleared by disable
            `SFCFE_OP_CLEAR_WRITE_LATCH_CMD_CODE:
              if (!busy)
                status_r[`SFCFE_ST_WEL_POS] <= 1'b0;
            `SFCFE_OP_PDN_CODE:
              if (!busy)
                power_down_r <= 1'b1;
            `SFCFE_OP_SIG_CODE:
              power_down_r <= 1'b0;
            `SFCFE_OP_STATUS_WRITE_CMD_CODE:
              // R9 R13 R20 status write gating
              if (write_enable_latch && !busy && !hw_lock)
              begin
                status_r[`SFCFE_ST_LOCK_POS] <= out_r[7];
                status_r[`SFCFE_ST_BP1_POS]  <= out_r[3];
                status_r[`SFCFE_ST_BP0_POS]  <= out_r[2];
                status_r[`SFCFE_ST_WEL_POS]  <= 1'b0;
                status_r[`SFCFE_ST_WIP_POS]  <= 1'b1;
                busy_cnt_r <= BUSY_CYCLES[15:0];
              end
            default:
              // R9 R12 program and erase gating
              if (write_enable_latch && !busy &&
                  (op_r == `SFCFE_OP_CHIP1_CODE ||
                   op_r == `SFCFE_OP_CHIP2_CODE ?
                   level == 2'd0 : !blocked(level, array_addr_r)))
              begin
                if (op_r == `SFCFE_OP_PROG_CODE)
                  prog_start_r <= 1'b1;
                else
                  erase_start_r <= 1'b1;
                erase_kind_r <= (op_r == `SFCFE_OP_SECT_CODE) ? 2'd0 :
                  (op_r == `SFCFE_OP_PROG_CODE) ? 2'd3 :
                  (op_r == `SFCFE_OP_BLK1_CODE ||
                   op_r == `SFCFE_OP_BLK2_CODE) ? 2'd1 : 2'd2;
                // R10 latch cleared on write command
                status_r[`SFCFE_ST_WEL_POS] <= 1'b0;
                status_r[`SFCFE_ST_WIP_POS] <= 1'b1;
                busy_cnt_r <= BUSY_CYCLES[15:0];
              end
          endcase
        end
      end
      // R4 sample on rising clock edge
      else if (active && sclk_rise)
      begin
        bit_r   <= bit_r + 3'd1;
        shift_r <= shift_nxt;
        if (bit_r == 3'd7)
        begin
          case (state_r)
            ST_CMD:
              // R2 unknown command is ignored
              if (!is_known(shift_nxt) ||
                  // R11 only release and signature in power-down
                  (power_down_r && shift_nxt != `SFCFE_OP_SIG_CODE))
              begin
                state_r   <= ST_IGN;
                bad_cmd_r <= 1'b1;
              end
              else
              begin
                // R3 stay active until select rises
                op_r      <= shift_nxt;
                out_idx_r <= 2'd0;
                if (needs_addr(shift_nxt))
                  state_r <= ST_ADDR;
                else if (shift_nxt == `SFCFE_OP_STATUS_READ_CMD_CODE ||
                         shift_nxt == `SFCFE_OP_IDENTIFICATION_READ_CMD_CODE ||
                         shift_nxt == `SFCFE_OP_SIG_CODE)
                  state_r <= ST_DATA;
                else
                  state_r <= ST_WAIT;
                out_r <= (shift_nxt == `SFCFE_OP_IDENTIFICATION_READ_CMD_CODE) ? MAKER_ID :
                         (shift_nxt == `SFCFE_OP_SIG_CODE) ? SIG_ID :
                         status_r;
              end
            ST_ADDR:
            begin
              // R1 R22 address assembled msb first within 18 bits
              array_addr_r <= {array_addr_r[9:0], shift_nxt};
              byte_r <= byte_r + 2'd1;
              if (byte_r == 2'd2)
              begin
                if (op_r == `SFCFE_OP_FAST_CODE ||
                    op_r == `SFCFE_OP_SFDP_CODE ||
                    op_r == `SFCFE_OP_DUAL_CODE)
                  state_r <= ST_DUMMY;
                else if (op_r == `SFCFE_OP_READ_CODE ||
                         op_r == `SFCFE_OP_MAKER_CODE)
                  state_r <= ST_DATA;
                else
                  state_r <= ST_WAIT;
                // R7 no array read while busy
                array_rd_r <= ~busy;
                out_idx_r  <= {1'b0, shift_nxt[0]};
                out_r      <= shift_nxt[0] ? TYPE_ID : MAKER_ID;
              end
            end
            ST_DUMMY:
            begin
              state_r    <= ST_DATA;
              array_rd_r <= ~busy;
            end
            ST_WAIT:
              if (op_r == `SFCFE_OP_STATUS_WRITE_CMD_CODE)
                out_r <= shift_nxt;
            // R5 next byte is loaded once the last bit has gone out
            ST_DATA:
            begin
              out_idx_r  <= idx_nxt;
              array_rd_r <= ~busy & arr_op;
              if (!arr_op)
                out_r <= (op_r == `SFCFE_OP_STATUS_READ_CMD_CODE) ? status_r :
                         (op_r == `SFCFE_OP_SIG_CODE) ? SIG_ID : id_byte;
            end
            default:
              state_r <= state_r;
          endcase
        end
      end
      // R5 shift out on falling edge, any bit may be the last
      else if (active && sclk_fall && state_r == ST_DATA)
      begin
        so_oe <= 1'b1;
        so_o  <= out_r[7];
        out_r <= {out_r[6:0], 1'b0};
        // Address moves on as soon as the byte starts going out.
        if (bit_r == 3'd0 && arr_op)
          array_addr_r <= (array_addr_r == `SFCFE_TOP_ADDR) ? 18'h00000 :
                          array_addr_r + 18'h00001;
      end
      // Array data stand in the same cycle as the request.
      if (array_rd_r && state_r == ST_DATA && arr_op)
        out_r <= array_rdata;
    end
  end
endmodule // sfcfe_front_end

/* File: hdl/sfcfe_consts.vh */
// Constants of the serial flash command front end.
// Assumes inclusion by plain Verilog-2005 design files only.
`ifndef SFCFE_CONSTS_VH
`define SFCFE_CONSTS_VH
`define SFCFE_OP_SET_WRITE_LATCH_CMD_CODE 8'h06
`define SFCFE_OP_CLEAR_WRITE_LATCH_CMD_CODE 8'h04
`define SFCFE_OP_STATUS_WRITE_CMD_CODE 8'h01
`define SFCFE_OP_IDENTIFICATION_READ_CMD_CODE 8'h9f
`define SFCFE_OP_STATUS_READ_CMD_CODE 8'h05
`define SFCFE_OP_READ_CODE 8'h03
`define SFCFE_OP_FAST_CODE 8'h0b
`define SFCFE_OP_SFDP_CODE 8'h5a
`define SFCFE_OP_DUAL_CODE 8'h3b
`define SFCFE_OP_SIG_CODE  8'hab
`define SFCFE_OP_MAKER_CODE 8'h90
`define SFCFE_OP_SECT_CODE 8'h20
`define SFCFE_OP_BLK1_CODE 8'h52
`define SFCFE_OP_BLK2_CODE 8'hd8
`define SFCFE_OP_CHIP1_CODE 8'h60
`define SFCFE_OP_CHIP2_CODE 8'hc7
`define SFCFE_OP_PROG_CODE 8'h02
`define SFCFE_OP_PDN_CODE  8'hb9
`define SFCFE_TOP_ADDR     18'h3ffff
`define SFCFE_SECTOR_MASK  18'h00fff
`define SFCFE_ST_WIP_POS   0
`define SFCFE_ST_WEL_POS   1
`define SFCFE_ST_BP0_POS   2
`define SFCFE_ST_BP1_POS   3
`define SFCFE_ST_LOCK_POS  7
`define SFCFE_ST_RESET     8'h00
`define SFCFE_BUSY_CYCLES  16
`endif

/* File: hdl/sfcfe_sync.v */
// Two-flop synchroniser bank for the serial pins.
// Assumes asynchronous inputs sampled on the block clock.
`timescale 1ns/10ps
module sfcfe_sync
#(
  parameter W = 5
)
(
  input  wire         mclk,
  input  wire         arst_n,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_r;
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // sfcfe_sync

/* File: tb/sfcfe_chk.sv */
// Port checker of the serial flash command front end.
// Assumes one clock domain and a bind onto the top module.
`timescale 1ns/10ps
module sfcfe_chk
(
  input wire        mclk,
  input wire        arst_n,
  input wire        sclk,
  input wire        cs_n,
  input wire        wp_n,
  input wire        pause_n,
  input wire        so_oe,
  input wire [17:0] array_addr_r,
  input wire        array_rd_r,
  input wire        prog_start_r,
  input wire        erase_start_r,
  input wire [7:0]  status_r,
  input wire        power_down_r,
  input wire        bad_cmd_r
);
  reg  ign_r;
  wire start_w = prog_start_r | erase_start_r;
  // A refused opcode leaves the part deaf until select rises.
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ign_r <= 1'b0;
    else
      ign_r <= bad_cmd_r | (ign_r & ~cs_n);
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  property p_deaf;
    ign_r |-> !so_oe && !start_w && !array_rd_r;
  endproperty
  a_deaf: assert property (p_deaf) else $error("active after bad opcode");
  property p_desel;
    cs_n [*6] |-> !so_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("output on while idle");
  property p_latch;
    start_w |-> $past(status_r[1], 2);
  endproperty
  a_latch: assert property (p_latch) else $error("write without latch");
  property p_clr;
    start_w |-> ##[0:4] !status_r[1];
  endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
  property p_busy;
    start_w |-> ##[0:3] status_r[0];
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag missing");
  property p_noacc;
    status_r[0] && $past(status_r[0]) |-> !start_w && !array_rd_r;
  endproperty
  a_noacc: assert property (p_noacc) else $error("access while busy");
  property p_prot;
    prog_start_r |-> status_r[3:2] != 2'b11 &&
      {1'b0, array_addr_r[17:16]} < 3'd4 - {1'b0, status_r[3:2]};
  endproperty
  a_prot: assert property (p_prot) else $error("protected program");
  property p_pdn;
    power_down_r && $past(power_down_r) |-> !start_w && !$rose(status_r[1]);
  endproperty
  a_pdn: assert property (p_pdn) else $error("write in power-down");
  property p_pause;
    (!pause_n && !sclk && !cs_n) [*6] |-> !so_oe;
  endproperty
  a_pause: assert property (p_pause) else $error("output on in pause");
  property p_hwl;
    (status_r[7] && !wp_n) [*4] |=> $stable(status_r[7:2]);
  endproperty
  a_hwl: assert property (p_hwl) else $error("locked bits changed");
endmodule // sfcfe_chk

/* File: tb/sfcfe_host.sv */
// Host controller model that drives the serial pins of the front end.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
module sfcfe_host
(
  output reg  sclk,
  output reg  cs_n,
  output reg  si,
  input  wire so
);
  reg cpol;
  initial
  begin
    cpol = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  task bitx(input b, output r);
  begin
    sclk = 1'b0;
    si = b;
    #62.5 sclk = 1'b1;
    r = so;
    #62.5;
  end
  endtask
  task xfer(input [7:0] tx, output [7:0] r);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bitx(tx[i], r[i]);
  end
  endtask
  task sel(input mode3);
  begin
    cpol = mode3;
    sclk = mode3;
    #62.5 cs_n = 1'b0;
    #62.5;
  end
  endtask
  task park;
  begin
    sclk = 1'b0;
    #62.5;
  end
  endtask
  task desel;
  begin
    sclk = cpol;
    #62.5 cs_n = 1'b1;
    #125;
  end
  endtask
endmodule // sfcfe_host

/* File: tb/tb_top.sv */
// Self-checking bench of the serial flash command front end.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/10ps
module tb_top;
  reg         mclk;
  reg         arst_n;
  reg         wp_n;
  reg         pause_n;
  reg         so_last;
  reg  [7:0]  rx;
  reg  [17:0] prog_addr;
  wire        sclk, cs_n, si, so_o, so_oe, array_rd_r;
  wire        prog_start_r, erase_start_r, power_down_r, bad_cmd_r;
  wire [1:0]  erase_kind_r;
  wire [7:0]  status_r;
  wire [17:0] array_addr_r;
  // A released output shows the opposite of its last driven bit.
  wire        so_w = so_oe ? so_o : ~so_last;
  wire [7:0]  array_rdata = array_addr_r[7:0] ^ 8'h5a;
  integer     error_cnt, cmp_count, n_prog, n_bad, n_rd, m;
  sfcfe_host u_host
  (
    .sclk (sclk),
    .cs_n (cs_n),
    .si   (si),
    .so   (so_w)
  );
  // The maker code is an arbitrary value.
  sfcfe_front_end #(.BUSY_CYCLES(2000), .MAKER_ID(8'h4d)) DUT
  (
    .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .pause_n(pause_n), .array_rdata(array_rdata),
    .so_o(so_o), .so_oe(so_oe), .array_addr_r(array_addr_r),
    .array_rd_r(array_rd_r), .prog_start_r(prog_start_r),
    .erase_start_r(erase_start_r), .erase_kind_r(erase_kind_r),
    .status_r(status_r), .power_down_r(power_down_r),
    .bad_cmd_r(bad_cmd_r)
  );
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (so_oe)
      so_last <= so_o;
    if (prog_start_r)
      prog_addr <= array_addr_r;
    n_prog <= n_prog + prog_start_r;
    n_bad <= n_bad + bad_cmd_r;
    n_rd <= n_rd + array_rd_r;
  end
  task final_report;
  begin
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
    end
  end
  endtask
  task idle;
    integer t;
  begin
    t = 0;
    while (status_r[0] !== 1'b0 && t < 3000)
    begin
      @(posedge mclk);
      t = t + 1;
    end
    if (t == 3000)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t busy flag stuck", $time);
      final_report;
    end
  end
  endtask
  task go(input m3, input integer n, input [39:0] s);
    integer i;
  begin
    u_host.sel(m3);
    for (i = 0; i < n; i = i + 1)
      u_host.xfer(s[39-8*i -: 8], rx);
  end
  endtask
  task run(input integer n, input [39:0] s);
  begin
    go(1'b0, n, s);
    u_host.desel;
  end
  endtask
  task status_write_cmd(input [7:0] v);
  begin
    run(1, {8'h06, 32'h0});
    run(2, {8'h01, v, 24'h0});
    idle;
  end
  endtask
  task hold(input v);
  begin
    u_host.park;
    @(posedge mclk);
    #1 pause_n = v;
    repeat (8) @(posedge mclk);
  end
  endtask
  task t_basic;
  begin
    chk(status_r, 8'h00);
    go(1'b1, 1, {8'h06, 32'h0});
    u_host.desel;
    chk(status_r[1], 1'b1);
    go(1'b1, 2, {8'h05, 32'h0});
    u_host.desel;
    chk(rx, 8'h02);
    run(1, {8'h04, 32'h0});
    chk(status_r[1], 1'b0);
    go(1'b0, 1, {8'h06, 32'h0});
    u_host.bitx(1'b0, rx[0]);
    u_host.desel;
    chk(status_r[1], 1'b0);
    m = n_bad;
    run(3, {8'hff, 8'h06, 24'h0});
    chk(n_bad, m + 1);
    chk(status_r[1], 1'b0);
  end
  endtask
  task t_read;
  begin
    go(1'b0, 5, {8'h03, 8'h01, 8'h23, 8'h45, 8'h00});
    chk(rx, 8'h45 ^ 8'h5a);
    u_host.xfer(8'h00, rx);
    chk(rx, 8'h46 ^ 8'h5a);
    u_host.desel;
    go(1'b1, 5, {8'h0b, 8'h01, 8'h23, 8'h45, 8'h00});
    u_host.xfer(8'h00, rx);
    u_host.desel;
    chk(rx, 8'h45 ^ 8'h5a);
    go(1'b0, 2, {8'h9f, 32'h0});
    u_host.desel;
    chk(rx, 8'h4d);
  end
  endtask
  task t_prot;
    integer l, b;
  begin
    for (l = 0; l < 4; l = l + 1)
    begin
      status_write_cmd({4'h0, l[1:0], 2'b00});
      chk(status_r[3:2], l);
      for (b = 0; b < 4; b = b + 1)
      begin
        m = n_prog;
        run(1, {8'h06, 32'h0});
        run(5, {8'h02, 6'h0, b[1:0], 16'hf0f0, 8'ha5});
        chk(n_prog - m, l < 3 && b < 4 - l);
        if (l < 3 && b < 4 - l)
          chk(prog_addr, {b[1:0], 16'hf0f0});
        idle;
      end
    end
    status_write_cmd(8'h00);
    run(1, {8'h06, 32'h0});
    run(5, {8'h02, 32'h11});
    chk(status_r[1:0], 2'b01);
    m = n_rd;
    run(5, {8'h03, 32'h0});
    chk(n_rd, m);
    idle;
    chk(status_r, 8'h00);
    run(1, {8'h06, 32'h0});
    run(4, {8'hd8, 24'h010000, 8'h00});
    chk(erase_kind_r, 2'd1);
    chk(status_r[1:0], 2'b01);
    idle;
  end
  endtask
  task t_lock;
  begin
    status_write_cmd(8'h80);
    @(posedge mclk);
    #1 wp_n = 1'b0;
    status_write_cmd(8'h0c);
    chk(status_r[7:2], 6'h20);
    @(posedge mclk);
    #1 wp_n = 1'b1;
    status_write_cmd(8'h0c);
    chk(status_r, 8'h0c);
    status_write_cmd(8'h00);
    run(1, {8'hb9, 32'h0});
    chk(power_down_r, 1'b1);
    m = n_bad;
    run(1, {8'h06, 32'h0});
    chk(n_bad - m + status_r[1], 1);
    run(1, {8'hab, 32'h0});
    chk(power_down_r, 1'b0);
  end
  endtask
  task t_pause;
    integer k;
  begin
    run(1, {8'h06, 32'h0});
    u_host.sel(1'b0);
    for (k = 0; k < 4; k = k + 1)
      u_host.bitx(1'b0, rx[k]);
    hold(1'b0);
    u_host.xfer(8'hff, rx);
    hold(1'b1);
    for (k = 0; k < 4; k = k + 1)
      u_host.bitx(k[0], rx[k]);
    u_host.xfer(8'h00, rx);
    u_host.desel;
    chk(rx, 8'h02);
    u_host.sel(1'b0);
    u_host.bitx(1'b1, rx[0]);
    hold(1'b0);
    u_host.desel;
    hold(1'b1);
    go(1'b0, 2, {8'h05, 32'h0});
    u_host.desel;
    chk(rx, 8'h02);
  end
  endtask
  initial
  begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    pause_n = 1'b1;
    so_last = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    n_prog = 0;
    n_bad = 0;
    n_rd = 0;
    repeat (2) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge mclk);
    t_basic;
    t_read;
    t_prot;
    t_lock;
    t_pause;
    final_report;
  end
endmodule // tb_top
bind sfcfe_front_end sfcfe_chk u_chk
(
  .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .wp_n(wp_n),
  .pause_n(pause_n), .so_oe(so_oe), .array_addr_r(array_addr_r),
  .array_rd_r(array_rd_r), .prog_start_r(prog_start_r),
  .erase_start_r(erase_start_r), .status_r(status_r),
  .power_down_r(power_down_r), .bad_cmd_r(bad_cmd_r)
);
